// >>> pio_pair.sv
`timescale 1ns/10ps
`include "pio_regs.svh"

// Notes on behaviour
// - Differential value follows the true pad; both pins then read that value.
// - Input goes straight to fabric or through an input register.
// - Bank hold freezes fabric value of latch-controlled unregistered inputs.
// - Hold low: follow the pad; hold high: keep last captured value.
// - Latch-bypassed unregistered pins always pass the pad, whatever the hold.
// - Floating pad reads 1 with pull-up on, undefined without.
// - Four bank hold inputs, each acting only on its own bank.
// - Bank hold levels come from fabric logic, not a dedicated pin.
// - Dedicated clock pad feeds the global net, never blocked by hold.
// - Global clock taken from an ordinary pin is blockable by hold.
// - Pull-ups of banks 0 to 2 forced on during configuration.
// - After configuration pull-up follows its bit; bank 3 has none.
// - Pin flops clear at end of configuration; optional inversion of registered output.
// - Output data drives the pad directly or via an output flop.
// - Enable high or unused drives data; enable low gives high-impedance.
// - Enable goes to the buffer directly or through its own register.
// - Buffer can be forced always on or always off by configuration.
// - Registered inputs ignore hold; only strobe or gate freezes them.
// - Capture strobe clocks input flops; launch strobe output and enable.
// - Pair gate enables all pair registers when used, else always on.

module pio_pair #(
   parameter int          NUM_BANKS        = 4,
   parameter int          PINS             = 2,
   parameter bit          BANK3_HAS_PULLUP = 1'b0
) (
   // Clock and reset
   input  wire logic               mclk_i,
   input  wire logic               rstn_i,
   // APB slave
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [11:0]        paddr_i,
   input  wire logic [31:0]        pwdata_i,
   output logic      [31:0]        prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   // Configuration sequencer
   input  wire logic               cfg_busy_i,
   // Fabric side
   input  wire logic [NUM_BANKS-1:0] hold_i,
   input  wire logic [PINS-1:0]    fabric_out_i,
   input  wire logic [PINS-1:0]    fabric_oe_i,
   input  wire logic               capture_clock_rx_i,
   input  wire logic               launch_clock_tx_i,
   input  wire logic               pair_register_gate_i,
   output logic      [PINS-1:0]    fabric_in_o,
   output logic                    diff_rx_o,
   output logic                    pin_clock_net_o,
   // Pads
   input  wire logic [PINS-1:0]    pad_in_i,
   output logic      [PINS-1:0]    pad_out_o,
   output logic      [PINS-1:0]    pad_oe_o,
   output logic      [PINS-1:0]    pullup_en_o,
   input  wire logic               dedicated_clock_pad_i,
   output logic                    global_clock_net_o
);

   // ************************************************************
   // Declarations
   // ************************************************************
   pio_pkg::pin_cfg_t   pin_cfg_ff [PINS];
   pio_pkg::pin_drive_t drive      [PINS];
   logic [`PAIR_W-1:0]  pair_cfg_ff;
   logic [PINS-1:0]     pad_s1_ff;
   logic [PINS-1:0]     pad_s2_ff;
   logic                dclk_s1_ff;
   logic                dclk_s2_ff;
   logic                diff_ff;
   logic                busy_q_ff;
   logic                cfg_done;
   logic                gate_ok;
   logic                cap_en;
   logic                lau_en;
   logic [PINS-1:0]     cell_pad;
   logic [PINS-1:0]     cell_in;
   logic [PINS-1:0]     nxt_pullup;
   logic [PINS-1:0]     pin_hold;
   logic                diff_true_pad;
   logic                diff_complement_pad;
   logic [31:0]         nxt_prdata;
   logic                addr_hit;
   logic                setup_ph;
   logic                wr_take;
   logic [`STAT_W-1:0]  status;

   // ************************************************************
   // Helper functions
   // ************************************************************

   // Pull-up presence depends on bank; bank 3 lacks one on large parts
   function automatic logic bank_has_pu(input logic [1:0] bank);
      bank_has_pu = (bank != `NOPU_BANK) || BANK3_HAS_PULLUP;
   endfunction

   // Address decode, used by write strobe and error answer
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `PIN0_CFG_OFS) || (a == `PIN1_CFG_OFS) ||
                  (a == `PAIR_CFG_OFS) || (a == `PIN_STATUS_OFS);
   endfunction

   // ************************************************************
   // Pad synchronisers
   // ************************************************************

   // Pads are asynchronous; second stage is the only reader of the first
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         pad_s1_ff  <= '0;
         pad_s2_ff  <= '0;
         dclk_s1_ff <= 1'b0;
         dclk_s2_ff <= 1'b0;
      end else begin
         pad_s1_ff  <= pad_in_i;
         pad_s2_ff  <= pad_s1_ff;
         dclk_s1_ff <= dedicated_clock_pad_i;
         dclk_s2_ff <= dclk_s1_ff;
      end
   end

   // Dedicated clock pad skips hold latch and input logic
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         global_clock_net_o <= 1'b0;
      end else begin
         global_clock_net_o <= dclk_s2_ff;
      end
   end

   // ************************************************************
   // Differential receiver
   // ************************************************************

   // Pin 1 carries the true signal, pin 0 the complement
   assign diff_true_pad       = pad_s2_ff[1];
   assign diff_complement_pad = pad_s2_ff[0];

   // Equal levels are not a valid differential state; keep last value
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         diff_ff <= 1'b0;
      end else if (diff_true_pad != diff_complement_pad) begin
         diff_ff <= diff_true_pad;
      end
   end

   // ************************************************************
   // Configuration end and register strobes
   // ************************************************************

   // Falling edge of the busy level marks the end of configuration
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         busy_q_ff <= 1'b0;
      end else begin
         busy_q_ff <= cfg_busy_i;
      end
   end
   assign cfg_done = busy_q_ff & ~cfg_busy_i;

   // Unused gate leaves the pair registers always enabled
   assign gate_ok = ~pair_cfg_ff[`PAIR_GATE_BIT] |
                    pair_register_gate_i;
   assign cap_en  = capture_clock_rx_i & gate_ok;
   assign lau_en  = launch_clock_tx_i & gate_ok;

   // ************************************************************
   // Pin cells
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++) begin : g_pin
         // Each pin picks the hold of its own bank from fabric
         assign pin_hold[gi] = hold_i[pin_cfg_ff[gi].bank];

         // In differential mode both pins see the received value
         assign cell_pad[gi] = pair_cfg_ff[`PAIR_DIFF_BIT] ? diff_ff
                                                          : pad_s2_ff[gi];

         pio_cell u_cell (
            .mclk_i   (mclk_i),
            .rstn_i   (rstn_i),
            .clr_i    (cfg_done),
            .cfg_i    (pin_cfg_ff[gi]),
            .hold_i   (pin_hold[gi]),
            .cap_en_i (cap_en),
            .lau_en_i (lau_en),
            .pad_i    (cell_pad[gi]),
            .out_i    (fabric_out_i[gi]),
            .oe_i     (fabric_oe_i[gi]),
            .fabric_o (cell_in[gi]),
            .drive_o  (drive[gi])
         );

         // Forced on during configuration, then per bit, never in bank 3
         assign nxt_pullup[gi] = bank_has_pu(pin_cfg_ff[gi].bank) &&
                                 (cfg_busy_i ||
                                  pin_cfg_ff[gi].pu_en);
      end
   endgenerate

   // ************************************************************
   // Output registers toward pads and fabric
   // ************************************************************

   // Pad level stays defined when undriven; enable decides high-impedance
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         pad_out_o <= '0;
         pad_oe_o  <= '0;
      end else begin
         for (int i = 0; i < PINS; i++) begin
            pad_out_o[i] <= drive[i].data;
            pad_oe_o[i]  <= drive[i].oe;
         end
      end
   end

   // Pull-up enables; the bench resolves a floating pad to 1 from these
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         pullup_en_o <= '1;
      end else begin
         pullup_en_o <= nxt_pullup;
      end
   end

   // Pin 0 input also feeds a global net, so hold can block it
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         fabric_in_o     <= '0;
         diff_rx_o       <= 1'b0;
         pin_clock_net_o <= 1'b0;
      end else begin
         fabric_in_o     <= cell_in;
         diff_rx_o       <= diff_ff;
         pin_clock_net_o <= cell_in[0];
      end
   end

   // ************************************************************
   // APB slave
   // ************************************************************

   // Zero wait states; read data is loaded in the setup cycle
   assign setup_ph  = psel_i & ~penable_i;
   assign addr_hit  = is_mapped(paddr_i);
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~addr_hit;
   assign wr_take   = psel_i & penable_i & pwrite_i & addr_hit;

   assign status = {pad_oe_o, diff_ff, pullup_en_o, cfg_busy_i,
                    hold_i, pad_s2_ff, cell_in};

   // Read mux; unmapped addresses read as zero
   always_comb begin
      nxt_prdata = '0;
      case (paddr_i)
         `PIN0_CFG_OFS:   nxt_prdata[`CFG_W-1:0]  = pin_cfg_ff[0];
         `PIN1_CFG_OFS:   nxt_prdata[`CFG_W-1:0]  = pin_cfg_ff[1];
         `PAIR_CFG_OFS:   nxt_prdata[`PAIR_W-1:0] = pair_cfg_ff;
         `PIN_STATUS_OFS: nxt_prdata[`STAT_W-1:0] = status;
         default:         nxt_prdata = '0;
      endcase
   end

   // Read data register
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         prdata_o <= '0;
      end else if (setup_ph && !pwrite_i) begin
         prdata_o <= nxt_prdata;
      end
   end

   // Configuration registers survive the end-of-configuration clear
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         pin_cfg_ff[0] <= `PIN_CFG_RST;
         pin_cfg_ff[1] <= `PIN_CFG_RST;
         pair_cfg_ff   <= `PAIR_CFG_RST;
      end else if (wr_take) begin
         case (paddr_i)
            `PIN0_CFG_OFS: pin_cfg_ff[0] <= pwdata_i[`CFG_W-1:0];
            `PIN1_CFG_OFS: pin_cfg_ff[1] <= pwdata_i[`CFG_W-1:0];
            `PAIR_CFG_OFS: pair_cfg_ff   <= pwdata_i[`PAIR_W-1:0];
            default:       pair_cfg_ff   <= pair_cfg_ff;
         endcase
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   diff_follow_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      diff_true_pad != diff_complement_pad
      |=> diff_ff == $past(diff_true_pad))
      else $error("differential value not from true pad");

   busy_pullup_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      cfg_busy_i && pin_cfg_ff[0].bank != `NOPU_BANK
      |=> pullup_en_o[0])
      else $error("pull-up off during configuration");

   bank3_nopu_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      !BANK3_HAS_PULLUP && pin_cfg_ff[1].bank == `NOPU_BANK
      |=> !pullup_en_o[1])
      else $error("bank 3 pin has pull-up");

   pu_bit_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      !cfg_busy_i && pin_cfg_ff[0].bank != `NOPU_BANK
      |=> pullup_en_o[0] == $past(pin_cfg_ff[0].pu_en))
      else $error("pull-up not following its bit");

   forced_off_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      pin_cfg_ff[0].oe_mode == pio_pkg::OE_ALWAYS_OFF
      |=> !pad_oe_o[0])
      else $error("input-only pin driving");

   forced_on_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      pin_cfg_ff[1].oe_mode == pio_pkg::OE_ALWAYS_ON
      |=> pad_oe_o[1])
      else $error("output-only pin not driving");

   dclk_direct_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      dclk_s2_ff |=> global_clock_net_o)
      else $error("dedicated clock blocked");

   // Holds on other banks must not freeze a pin whose own bank is free
   bank_hold_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      !pin_cfg_ff[0].in_reg && !pair_cfg_ff[`PAIR_DIFF_BIT] &&
      !hold_i[pin_cfg_ff[0].bank] |-> cell_in[0] == pad_s2_ff[0])
      else $error("input frozen while own bank not held");

   gate_off_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      pair_cfg_ff[`PAIR_GATE_BIT] && !pair_register_gate_i
      |-> !cap_en && !lau_en)
      else $error("pair registers enabled while gated");

endmodule

// >>> pio_regs.svh
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

// ************************************************************
// Register offsets (byte addresses, one word each)
// ************************************************************
`define PIN0_CFG_OFS   12'h000
`define PIN1_CFG_OFS   12'h004
`define PAIR_CFG_OFS   12'h008
`define PIN_STATUS_OFS 12'h00c

// ************************************************************
// Reset values and field positions
// ************************************************************
`define PIN_CFG_RST    10'h000
`define PAIR_CFG_RST   2'h0
`define PAIR_DIFF_BIT  0
`define PAIR_GATE_BIT  1
`define CFG_W          10
`define PAIR_W         2
`define STAT_W         14

// Bank without pull-up resistors
`define NOPU_BANK      2'h3

`endif

// >>> pio_pkg.sv
package pio_pkg;

   // Output buffer enable source
   typedef enum logic [1:0] {
      OE_SIGNAL,
      OE_ALWAYS_ON,
      OE_ALWAYS_OFF
   } oe_mode_t;

   // Per pin configuration word, low bit is in_reg
   typedef struct packed {
      logic [1:0] bank;
      logic       out_inv;
      oe_mode_t   oe_mode;
      logic       oe_reg;
      logic       out_reg;
      logic       pu_en;
      logic       hold_ctl;
      logic       in_reg;
   } pin_cfg_t;

   // Pad drive pair: level and enable travel together
   typedef struct packed {
      logic data;
      logic oe;
   } pin_drive_t;

endpackage

// >>> pio_cell.sv
`timescale 1ns/10ps
`include "pio_regs.svh"

module pio_cell (
   // Clock and clear
   input  wire logic               mclk_i,
   input  wire logic               rstn_i,
   input  wire logic               clr_i,
   // Configuration and controls
   input  wire pio_pkg::pin_cfg_t  cfg_i,
   input  wire logic               hold_i,
   input  wire logic               cap_en_i,
   input  wire logic               lau_en_i,
   // Data
   input  wire logic               pad_i,
   input  wire logic               out_i,
   input  wire logic               oe_i,
   output logic                    fabric_o,
   output pio_pkg::pin_drive_t     drive_o
);

   logic in_ff;
   logic latch_ff;
   logic out_ff;
   logic oe_ff;
   logic held;
   logic unreg;
   logic oe_v;

   // ************************************************************
   // Input path
   // ************************************************************

   // Input register runs only on the gated capture strobe
   always_ff @(posedge mclk_i) begin
      if (!rstn_i || clr_i) begin
         in_ff <= 1'b0;
      end else if (cap_en_i) begin
         in_ff <= pad_i;
      end
   end

   // Hold latch: follows pad while hold is low, freezes when high
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         latch_ff <= 1'b0;
      end else if (!hold_i) begin
         latch_ff <= pad_i;
      end
   end

   // Bypassed pins ignore the hold level entirely
   assign held  = cfg_i.hold_ctl & hold_i;
   assign unreg = held ? latch_ff : pad_i;
   assign fabric_o = cfg_i.in_reg ? in_ff : unreg;

   // ************************************************************
   // Output and enable path
   // ************************************************************

   // Both output-side registers share the launch strobe
   always_ff @(posedge mclk_i) begin
      if (!rstn_i || clr_i) begin
         out_ff <= 1'b0;
         oe_ff  <= 1'b0;
      end else if (lau_en_i) begin
         out_ff <= out_i;
         oe_ff  <= oe_i;
      end
   end

   // Inversion lets an active-low registered output idle high
   assign drive_o.data = cfg_i.out_reg ? (out_ff ^ cfg_i.out_inv)
                                       : out_i;
   assign oe_v = cfg_i.oe_reg ? oe_ff : oe_i;

   // Forced modes override the enable signal
   always_comb begin
      case (cfg_i.oe_mode)
         pio_pkg::OE_ALWAYS_ON:  drive_o.oe = 1'b1;
         pio_pkg::OE_ALWAYS_OFF: drive_o.oe = 1'b0;
         default:                drive_o.oe = oe_v;
      endcase
   end

   // ************************************************************
   // Checks
   // ************************************************************
   hold_keeps_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      held && $past(held) |-> unreg == $past(unreg))
      else $error("held input changed");
   bypass_pass_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      !cfg_i.hold_ctl && !cfg_i.in_reg |-> fabric_o == pad_i)
      else $error("bypassed input not following pad");
   end_clear_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      clr_i |=> !in_ff && !out_ff && !oe_ff)
      else $error("pin flops not cleared");
   in_gated_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      !cap_en_i && !clr_i |=> $stable(in_ff))
      else $error("input register moved without strobe");
   hiz_off_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      cfg_i.oe_mode == pio_pkg::OE_SIGNAL && !cfg_i.oe_reg && !oe_i
      |-> !drive_o.oe)
      else $error("driver on while enable low");

endmodule

// >>> ext_board.sv
`timescale 1ns/10ps

module ext_board (
   // Clock
   input  wire logic       mclk_i,
   // Device pin drive
   input  wire logic [1:0] pad_out_i,
   input  wire logic [1:0] pad_oe_i,
   input  wire logic [1:0] pullup_en_i,
   // Board drivers set by the bench
   input  wire logic [1:0] ext_drv_i,
   input  wire logic [1:0] ext_val_i,
   output logic      [1:0] pad_o
);
   logic [1:0] float_ff = 2'h1;

   // An unpulled, undriven line wanders, so a stale level never looks valid
   always_ff @(posedge mclk_i) begin
      float_ff <= ~float_ff;
   end

   // Pad level from all parties; the device driver wins over the board
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (pad_oe_i[i]) begin
            pad_o[i] = pad_out_i[i];
         end else if (ext_drv_i[i]) begin
            pad_o[i] = ext_val_i[i];
         end else if (pullup_en_i[i]) begin
            pad_o[i] = 1'b1;
         end else begin
            pad_o[i] = float_ff[i];
         end
      end
   end
endmodule

// >>> tb.sv
`timescale 1ns/10ps
`include "pio_regs.svh"

module tb;
   // Bench signals
   logic        mclk, rstn, psel, pen, pwr, busy, cap, lau, gate, dck;
   logic [11:0] paddr;
   logic [31:0] pwd, prd, rd;
   logic        pready, perr, er, diff, pclk, gck;
   logic [3:0]  hold;
   logic [1:0]  fout, foe, fin, pad, pout, poe, pu, edrv, eval;
   int          error_cnt, check_count;

   pio_pair i_dut (.mclk_i(mclk), .rstn_i(rstn), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd),
      .prdata_o(prd), .pready_o(pready), .pslverr_o(perr),
      .cfg_busy_i(busy), .hold_i(hold), .fabric_out_i(fout),
      .fabric_oe_i(foe), .capture_clock_rx_i(cap),
      .launch_clock_tx_i(lau), .pair_register_gate_i(gate),
      .fabric_in_o(fin), .diff_rx_o(diff), .pin_clock_net_o(pclk),
      .pad_in_i(pad), .pad_out_o(pout), .pad_oe_o(poe),
      .pullup_en_o(pu), .dedicated_clock_pad_i(dck),
      .global_clock_net_o(gck));

   ext_board i_board (.mclk_i(mclk), .pad_out_i(pout), .pad_oe_i(poe),
      .pullup_en_i(pu), .ext_drv_i(edrv), .ext_val_i(eval), .pad_o(pad));

   // 20 MHz clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // One APB transfer; the request stands until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge mclk);
      pen <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   // Strobe one of the pair clocks for a single cycle
   task automatic strobe(input bit rx);
      @(posedge mclk);
      if (rx) cap <= 1'b1; else lau <= 1'b1;
      @(posedge mclk);
      cap <= 1'b0;
      lau <= 1'b0;
      tick(3);
   endtask

   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Watchdog well beyond the couple of hundred cycles the tests need
   initial begin
      tick(20000);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      {psel, pen, pwr, cap, lau, gate, dck, rstn} = '0;
      {paddr, pwd, hold, fout, foe, edrv, eval} = '0;
      busy = 1'b1;
      tick(16);
      rstn <= 1'b1;
      // Reset values and an unmapped word
      for (int k = 0; k < 4; k++) begin
         apb(1'b0, (k == 3) ? 12'h010 : 12'(k * 4), 32'h0);
         chk(rd, 32'h0);
         chk(er, k == 3);
      end
      wr(`PIN1_CFG_OFS, 32'h204);
      apb(1'b0, `PIN1_CFG_OFS, 32'h0);
      chk(rd, 32'h204);
      tick(2);
      chk(pu, 2'h3);
      busy <= 1'b0;
      tick(3);
      chk(pu, 2'h2);
      wr(`PIN1_CFG_OFS, 32'h304);
      tick(2);
      chk(pu, 2'h0);
      $display("test config done");
      // Hold latch on pin0 (bank 1), pin1 bypasses it
      wr(`PIN0_CFG_OFS, 32'h102);
      wr(`PIN1_CFG_OFS, 32'h004);
      edrv <= 2'h3;
      eval <= 2'h1;
      tick(6);
      chk(fin, 2'h1);
      hold <= 4'h2;
      tick(2);
      eval <= 2'h2;
      tick(6);
      chk(fin, 2'h3);
      for (int k = 0; k < 2; k++) begin
         dck <= k[0];
         eval[0] <= k[0];
         tick(6);
         chk(gck, k);
         chk(pclk, 1'b1);
      end
      hold <= 4'hd;
      eval <= 2'h0;
      tick(6);
      chk(fin, 2'h0);
      edrv <= 2'h0;
      tick(6);
      chk(fin[1], 1'b1);
      $display("test hold done");
      // Registered input ignores hold, obeys strobe and pair gate
      wr(`PIN0_CFG_OFS, 32'h103);
      hold <= 4'h2;
      edrv <= 2'h1;
      eval <= 2'h1;
      tick(6);
      chk(fin[0], 1'b0);
      strobe(1'b0);
      chk(fin[0], 1'b0);
      strobe(1'b1);
      chk(fin[0], 1'b1);
      wr(`PAIR_CFG_OFS, 32'h2);
      eval <= 2'h0;
      tick(6);
      strobe(1'b1);
      chk(fin[0], 1'b1);
      gate <= 1'b1;
      strobe(1'b1);
      chk(fin[0], 1'b0);
      wr(`PAIR_CFG_OFS, 32'h0);
      $display("test registered input done");
      // Output and enable paths
      edrv <= 2'h0;
      wr(`PIN0_CFG_OFS, 32'h000);
      fout <= 2'h1;
      foe <= 2'h1;
      tick(3);
      chk({poe[0], pout[0]}, 2'h3);
      foe <= 2'h0;
      tick(3);
      chk(poe[0], 1'b0);
      wr(`PIN0_CFG_OFS, 32'h020);
      wr(`PIN1_CFG_OFS, 32'h024);
      tick(3);
      chk(poe, 2'h3);
      wr(`PIN0_CFG_OFS, 32'h040);
      foe <= 2'h1;
      tick(3);
      chk(poe[0], 1'b0);
      wr(`PIN0_CFG_OFS, 32'h018);
      tick(3);
      chk({poe[0], pout[0]}, 2'h0);
      strobe(1'b1);
      chk({poe[0], pout[0]}, 2'h0);
      strobe(1'b0);
      chk({poe[0], pout[0]}, 2'h3);
      wr(`PIN0_CFG_OFS, 32'h098);
      busy <= 1'b1;
      tick(2);
      busy <= 1'b0;
      tick(3);
      chk({poe[0], pout[0]}, 2'h1);
      $display("test output done");
      // Differential pair: pin1 true, pin0 complement
      wr(`PIN0_CFG_OFS, 32'h000);
      wr(`PIN1_CFG_OFS, 32'h004);
      wr(`PAIR_CFG_OFS, 32'h1);
      foe <= 2'h0;
      edrv <= 2'h3;
      for (int k = 1; k >= 0; k--) begin
         eval <= {k[0], ~k[0]};
         tick(7);
         chk(diff, k);
      end
      // Status: pads 01, bank 1 held, pin1 pull-up on, nothing driven
      apb(1'b0, `PIN_STATUS_OFS, 32'h0);
      chk(rd, 32'h424);
      $display("test differential done");
      report_and_stop();
   end
endmodule
